// >>> core/asc_pkg.sv
`default_nettype none
package asc_pkg;
	// Sizes
	localparam int NCH = 2;
	localparam int CH_W = 1;
	localparam int NTMR = 3;
	localparam int NCONV = 2;
	localparam int NOCU = 2;
	localparam int CNT_W = 16;
	localparam int MCNT_W = 4;
	localparam int PH_NUM = 4;
	localparam int XFER_W = 2;
	localparam int TSEL_W = 2;
	localparam int DEST_W = 1;
	localparam int MSK_W = 6;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	// Phase enable positions
	localparam int PHEN_ZERO_BIT = 0;
	localparam int PHEN_UP_BIT = 1;
	localparam int PHEN_PEAK_BIT = 2;
	localparam int PHEN_DOWN_BIT = 3;
	// Mask compare layout
	localparam int MCNT_LSB = 0;
	localparam int MSK_ZERO_BIT = 4;
	localparam int MSK_PEAK_BIT = 5;
	// Shadow transfer select
	localparam logic [XFER_W-1:0] XFER_NONE = 2'h0;
	localparam int XFER_ZERO_BIT = 0;
	localparam int XFER_PEAK_BIT = 1;
	// Reset values and other constants
	localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
	localparam logic [MSK_W-1:0] MSK_RST = 6'h00;
	localparam logic [MCNT_W-1:0] MCNT_ZERO = 4'h0;
	localparam logic [PH_NUM-1:0] PHEN_OFF = 4'h0;
	localparam logic [CNT_W-1:0] CTR_ONE = 16'h0001;
	// Register map
	localparam logic [APB_AW-1:0] MASK_BASE = 12'h040;
	localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h050;
	localparam int CH_LSB = 4;
	localparam int REG_LSB = 2;
	localparam logic [1:0] SLOT_MODE = 2'h0;
	localparam logic [1:0] SLOT_SETUP = 2'h1;
	localparam logic [1:0] SLOT_LINK = 2'h2;
	localparam logic [1:0] SLOT_CMP = 2'h3;
	// Mode control fields
	localparam int MODE_OFS_BIT = 4;
	localparam int MODE_TRIG_BIT = 5;
	// Setup control fields
	localparam int SETUP_XFER_LSB = 0;
	localparam int SETUP_LINK_BIT = 2;
	localparam int SETUP_DEST_LSB = 3;
	// Status fields
	localparam int STAT_EN_LSB = 0;
	localparam int STAT_BUSY_LSB = 8;

	typedef enum logic [2:0] {PH_STOP, PH_ZERO, PH_UP, PH_PEAK, PH_DOWN} asc_phase_e;
	typedef enum logic {OFS_IDLE, OFS_COUNT} asc_ofs_e;
	typedef enum logic [2:0] {K_MODE, K_SETUP, K_LINK, K_CMP, K_MASK, K_STATUS, K_NONE} asc_reg_e;
endpackage : asc_pkg
`default_nettype wire

// >>> core/asc_link_if.sv
`default_nettype none
interface asc_link_if;
	import asc_pkg::*;
	logic [NCH-1:0][PH_NUM-1:0] phase_en;
	logic [NCH-1:0] offset_mode;
	logic [NCH-1:0] trig_sel;
	logic [NCH-1:0][XFER_W-1:0] xfer_sel;
	logic [NCH-1:0] mask_link;
	logic [NCH-1:0][DEST_W-1:0] dest_sel;
	logic [NCH-1:0][TSEL_W-1:0] timer_sel;
	logic [NCH-1:0] cmp_wr;
	logic [NCH-1:0] msk_wr;
	logic [CNT_W-1:0] wr_data;
	logic [NCH-1:0][CNT_W-1:0] active_cmp;
	logic [NCH-1:0] ofs_busy;

	modport dev (
		input phase_en, offset_mode, trig_sel, xfer_sel, mask_link, dest_sel, timer_sel,
		input cmp_wr, msk_wr, wr_data,
		output active_cmp, ofs_busy
	);
	modport ctl (
		output phase_en, offset_mode, trig_sel, xfer_sel, mask_link, dest_sel, timer_sel,
		output cmp_wr, msk_wr, wr_data,
		input active_cmp, ofs_busy
	);
endinterface : asc_link_if
`default_nettype wire

// >>> core/asc_converter_start_comparator.sv
`default_nettype none
module asc_converter_start_comparator (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	// Timers
	input wire logic [asc_pkg::CNT_W-1:0] tmr_count [asc_pkg::NTMR],
	input wire asc_pkg::asc_phase_e tmr_phase [asc_pkg::NTMR],
	input wire logic [asc_pkg::MCNT_W-1:0] tmr_mask_cnt [asc_pkg::NTMR],
	// Output compare units
	input wire logic [asc_pkg::NOCU-1:0] oc_match,
	// Converter starts
	output logic [asc_pkg::NCONV-1:0] conv_start,
	// Controller link
	asc_link_if.dev lnk
);
	import asc_pkg::*;

	function automatic logic phase_hit(input asc_phase_e ph, input logic [PH_NUM-1:0] en);
		logic hit;
		hit = 1'b0;
		case (ph)
			PH_ZERO: hit = en[PHEN_ZERO_BIT];
			PH_UP: hit = en[PHEN_UP_BIT];
			PH_PEAK: hit = en[PHEN_PEAK_BIT];
			PH_DOWN: hit = en[PHEN_DOWN_BIT];
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : phase_hit

	function automatic logic mask_ok(input asc_phase_e ph, input logic [MSK_W-1:0] msk,
		input logic [MCNT_W-1:0] mcnt);
		logic chk;
		chk = ((ph == PH_ZERO) && msk[MSK_ZERO_BIT]) || ((ph == PH_PEAK) && msk[MSK_PEAK_BIT]);
		return !chk || (mcnt == msk[MCNT_LSB +: MCNT_W]);
	endfunction : mask_ok

	logic [NCH-1:0] nxt_start;
	logic [NCONV-1:0] nxt_conv;
	logic [NCONV-1:0] conv_start_ff;

	genvar c;
	generate
		for (c = 0; c < NCH; c++)
		begin : g_ch
			logic [TSEL_W-1:0] ti;
			logic [CNT_W-1:0] cnt;
			asc_phase_e ph;
			logic [MCNT_W-1:0] mcnt;
			logic counting;
			logic direct;
			logic at_xfer;
			logic enabled;
			logic hit;
			logic qual;
			logic trig;
			logic tick;
			logic [CNT_W-1:0] cmp_ff;
			logic [CNT_W-1:0] cmp_shadow_ff;
			logic [MSK_W-1:0] msk_ff;
			logic [MSK_W-1:0] msk_shadow_ff;
			logic qual_prev_ff;
			logic trig_prev_ff;
			logic [CNT_W-1:0] cnt_prev_ff;
			asc_ofs_e state_ff;
			asc_ofs_e nxt_state;
			logic [CNT_W-1:0] ctr_ff;
			logic [CNT_W-1:0] nxt_ctr;
			logic ofs_fire;

			// Out-of-range timer selection falls back to timer 0
			assign ti = (lnk.timer_sel[c] < TSEL_W'(NTMR)) ? lnk.timer_sel[c] : '0;
			assign cnt = tmr_count[ti];
			assign ph = tmr_phase[ti];
			assign mcnt = tmr_mask_cnt[ti];

			assign counting = (ph != PH_STOP);
			assign direct = (lnk.xfer_sel[c] == XFER_NONE) || !counting;
			assign at_xfer = ((lnk.xfer_sel[c][XFER_ZERO_BIT] && (ph == PH_ZERO))
				|| (lnk.xfer_sel[c][XFER_PEAK_BIT] && (ph == PH_PEAK)))
				&& (!lnk.mask_link[c] || (mcnt == MCNT_ZERO));

			// Compare value with shadow
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cmp_ff <= CMP_RST;
					cmp_shadow_ff <= CMP_RST;
				end
				else if (pclk_en)
				begin
					if (lnk.cmp_wr[c])
						cmp_shadow_ff <= lnk.wr_data;
					if (lnk.cmp_wr[c] && direct)
						cmp_ff <= lnk.wr_data;
					else if (at_xfer)
						cmp_ff <= cmp_shadow_ff;
				end
			end

			// Mask compare with shadow
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					msk_ff <= MSK_RST;
					msk_shadow_ff <= MSK_RST;
				end
				else if (pclk_en)
				begin
					if (lnk.msk_wr[c])
						msk_shadow_ff <= lnk.wr_data[MSK_W-1:0];
					if (lnk.msk_wr[c] && direct)
						msk_ff <= lnk.wr_data[MSK_W-1:0];
					else if (at_xfer)
						msk_ff <= msk_shadow_ff;
				end
			end

			assign enabled = |lnk.phase_en[c];
			assign hit = phase_hit(ph, lnk.phase_en[c]) && mask_ok(ph, msk_ff, mcnt);
			// Plain equality only; stop phase has no enable
			assign qual = enabled && !lnk.offset_mode[c] && (cnt == cmp_ff) && hit;
			assign trig = enabled && lnk.offset_mode[c] && oc_match[lnk.trig_sel[c]] && hit;
			assign tick = (cnt != cnt_prev_ff);

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					qual_prev_ff <= 1'b0;
					trig_prev_ff <= 1'b0;
					cnt_prev_ff <= CMP_RST;
				end
				else if (pclk_en)
				begin
					qual_prev_ff <= qual;
					trig_prev_ff <= trig;
					cnt_prev_ff <= cnt;
				end
			end

			// Offset delay counter, one step per timer count change
			always_comb
			begin
				nxt_state = state_ff;
				nxt_ctr = ctr_ff;
				ofs_fire = 1'b0;
				if (!enabled || !lnk.offset_mode[c])
				begin
					nxt_state = OFS_IDLE;
					nxt_ctr = CMP_RST;
				end
				else if (trig && !trig_prev_ff)
				begin
					if (cmp_ff == CMP_RST)
					begin
						ofs_fire = 1'b1;
						nxt_state = OFS_IDLE;
					end
					else
					begin
						nxt_state = OFS_COUNT;
						nxt_ctr = cmp_ff;
					end
				end
				else
				begin
					case (state_ff)
						OFS_IDLE: nxt_state = OFS_IDLE;
						OFS_COUNT:
						begin
							if (tick && (ctr_ff == CTR_ONE))
							begin
								ofs_fire = 1'b1;
								nxt_state = OFS_IDLE;
								nxt_ctr = CMP_RST;
							end
							else if (tick)
								nxt_ctr = ctr_ff - CTR_ONE;
						end
						default: nxt_state = OFS_IDLE;
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					state_ff <= OFS_IDLE;
					ctr_ff <= CMP_RST;
				end
				else if (pclk_en)
				begin
					state_ff <= nxt_state;
					ctr_ff <= nxt_ctr;
				end
			end

			assign nxt_start[c] = (qual && !qual_prev_ff) || ofs_fire;
			assign lnk.active_cmp[c] = cmp_ff;
			assign lnk.ofs_busy[c] = (state_ff == OFS_COUNT);
		end
	endgenerate

	// Merge channel starts per destination
	always_comb
	begin
		nxt_conv = '0;
		for (int k = 0; k < NCONV; k++)
			for (int i = 0; i < NCH; i++)
				if (lnk.dest_sel[i] == DEST_W'(k))
					nxt_conv[k] = nxt_conv[k] | nxt_start[i];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conv_start_ff <= '0;
		else if (pclk_en)
			conv_start_ff <= nxt_conv;
		else
			conv_start_ff <= '0;
	end

	assign conv_start = conv_start_ff;
endmodule : asc_converter_start_comparator
`default_nettype wire

// >>> core/asc_channel_ctl.sv
`default_nettype none
module asc_channel_ctl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [asc_pkg::APB_AW-1:0] paddr,
	input wire logic [asc_pkg::APB_DW-1:0] pwdata,
	output logic [asc_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Comparator link
	asc_link_if.ctl lnk
);
	import asc_pkg::*;

	function automatic asc_reg_e reg_kind(input logic [APB_AW-1:0] a);
		asc_reg_e k;
		k = K_NONE;
		if (a[REG_LSB-1:0] != '0)
			k = K_NONE;
		else if (a < MASK_BASE)
		begin
			if (a[APB_AW-1:CH_LSB] < NCH)
			begin
				case (a[CH_LSB-1:REG_LSB])
					SLOT_MODE: k = K_MODE;
					SLOT_SETUP: k = K_SETUP;
					SLOT_LINK: k = K_LINK;
					SLOT_CMP: k = K_CMP;
					default: k = K_NONE;
				endcase
			end
		end
		else if ((a[APB_AW-1:CH_LSB] == MASK_BASE[APB_AW-1:CH_LSB]) && (a[CH_LSB-1:REG_LSB] < NCH))
			k = K_MASK;
		else if (a == STATUS_ADDR)
			k = K_STATUS;
		return k;
	endfunction : reg_kind

	function automatic logic [CH_W-1:0] ch_of(input logic [APB_AW-1:0] a);
		return (a < MASK_BASE) ? a[CH_LSB +: CH_W] : a[REG_LSB +: CH_W];
	endfunction : ch_of

	logic [NCH-1:0][PH_NUM-1:0] phase_en_ff;
	logic [NCH-1:0] offset_ff;
	logic [NCH-1:0] trig_ff;
	logic [NCH-1:0][XFER_W-1:0] xfer_ff;
	logic [NCH-1:0] link_ff;
	logic [NCH-1:0][DEST_W-1:0] dest_ff;
	logic [NCH-1:0][TSEL_W-1:0] tsel_ff;
	logic [NCH-1:0][MSK_W-1:0] msk_copy_ff;
	logic [NCH-1:0] cmp_wr_ff;
	logic [NCH-1:0] msk_wr_ff;
	logic [CNT_W-1:0] wr_data_ff;
	logic [APB_DW-1:0] prdata_ff;
	logic rd_ready_ff;
	logic [APB_DW-1:0] rd_value;
	asc_reg_e kind;
	logic [CH_W-1:0] ch;
	logic done;
	logic wr_done;
	logic [NCH-1:0] enabled;

	assign kind = reg_kind(paddr);
	assign ch = ch_of(paddr);
	assign pready = pclk_en && (pwrite || rd_ready_ff);
	assign done = psel && penable && pready;
	assign wr_done = done && pwrite && (kind != K_NONE);
	assign pslverr = psel && penable && (kind == K_NONE);
	assign prdata = prdata_ff;

	always_comb
	begin
		for (int i = 0; i < NCH; i++)
			enabled[i] = |phase_en_ff[i];
	end

	// Channel configuration with locks while enabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_en_ff <= '0;
			offset_ff <= '0;
			trig_ff <= '0;
			xfer_ff <= '0;
			link_ff <= '0;
			dest_ff <= '0;
			tsel_ff <= '0;
			msk_copy_ff <= '0;
		end
		else if (pclk_en && wr_done)
		begin
			case (kind)
				K_MODE:
				begin
					phase_en_ff[ch] <= pwdata[PHEN_ZERO_BIT +: PH_NUM];
					if (!enabled[ch] || (pwdata[PHEN_ZERO_BIT +: PH_NUM] == PHEN_OFF))
					begin
						offset_ff[ch] <= pwdata[MODE_OFS_BIT];
						trig_ff[ch] <= pwdata[MODE_TRIG_BIT];
					end
				end
				K_SETUP:
				begin
					if (!enabled[ch])
					begin
						xfer_ff[ch] <= pwdata[SETUP_XFER_LSB +: XFER_W];
						link_ff[ch] <= pwdata[SETUP_LINK_BIT];
						dest_ff[ch] <= pwdata[SETUP_DEST_LSB +: DEST_W];
					end
				end
				K_LINK:
				begin
					if (!enabled[ch] && (pwdata[TSEL_W-1:0] < TSEL_W'(NTMR)))
						tsel_ff[ch] <= pwdata[TSEL_W-1:0];
				end
				K_MASK: msk_copy_ff[ch] <= pwdata[MSK_W-1:0];
				default: msk_copy_ff <= msk_copy_ff;
			endcase
		end
	end

	// Write strobes towards the comparator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_wr_ff <= '0;
			msk_wr_ff <= '0;
			wr_data_ff <= CMP_RST;
		end
		else if (pclk_en)
		begin
			cmp_wr_ff <= '0;
			msk_wr_ff <= '0;
			if (wr_done && (kind == K_CMP))
			begin
				cmp_wr_ff[ch] <= 1'b1;
				wr_data_ff <= pwdata[CNT_W-1:0];
			end
			else if (wr_done && (kind == K_MASK))
			begin
				msk_wr_ff[ch] <= 1'b1;
				wr_data_ff <= pwdata[CNT_W-1:0];
			end
		end
	end

	always_comb
	begin
		rd_value = '0;
		case (kind)
			K_MODE: rd_value = APB_DW'({trig_ff[ch], offset_ff[ch], phase_en_ff[ch]});
			K_SETUP: rd_value = APB_DW'({dest_ff[ch], link_ff[ch], xfer_ff[ch]});
			K_LINK: rd_value = APB_DW'(tsel_ff[ch]);
			K_CMP: rd_value = APB_DW'(lnk.active_cmp[ch]);
			K_MASK: rd_value = APB_DW'(msk_copy_ff[ch]);
			K_STATUS:
			begin
				rd_value[STAT_EN_LSB +: NCH] = enabled;
				rd_value[STAT_BUSY_LSB +: NCH] = lnk.ofs_busy;
			end
			default: rd_value = '0;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= '0;
			rd_ready_ff <= 1'b0;
		end
		else if (pclk_en)
		begin
			if (psel && !penable && !pwrite)
			begin
				prdata_ff <= rd_value;
				rd_ready_ff <= 1'b1;
			end
			else if (done)
				rd_ready_ff <= 1'b0;
		end
	end

	assign lnk.phase_en = phase_en_ff;
	assign lnk.offset_mode = offset_ff;
	assign lnk.trig_sel = trig_ff;
	assign lnk.xfer_sel = xfer_ff;
	assign lnk.mask_link = link_ff;
	assign lnk.dest_sel = dest_ff;
	assign lnk.timer_sel = tsel_ff;
	assign lnk.cmp_wr = cmp_wr_ff;
	assign lnk.msk_wr = msk_wr_ff;
	assign lnk.wr_data = wr_data_ff;
endmodule : asc_channel_ctl
`default_nettype wire

// >>> dv/asc_link_props.sv
`default_nettype none
module asc_link_props
	import asc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic [asc_pkg::NCH-1:0][asc_pkg::PH_NUM-1:0] phase_en,
	input wire logic [asc_pkg::NCH-1:0] offset_mode,
	input wire logic [asc_pkg::NCH-1:0] trig_sel,
	input wire logic [asc_pkg::NCH-1:0][asc_pkg::XFER_W-1:0] xfer_sel,
	input wire logic [asc_pkg::NCH-1:0][asc_pkg::DEST_W-1:0] dest_sel,
	input wire logic [asc_pkg::NCH-1:0][asc_pkg::TSEL_W-1:0] timer_sel,
	input wire logic [asc_pkg::NCH-1:0] cmp_wr,
	input wire logic [asc_pkg::CNT_W-1:0] wr_data,
	input wire logic [asc_pkg::NCH-1:0][asc_pkg::CNT_W-1:0] active_cmp,
	input wire logic [asc_pkg::NCH-1:0] ofs_busy,
	// Timers and starts
	input wire logic [asc_pkg::CNT_W-1:0] tmr_count [asc_pkg::NTMR],
	input wire asc_pkg::asc_phase_e tmr_phase [asc_pkg::NTMR],
	input wire logic [asc_pkg::NCONV-1:0] conv_start
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_off;
		phase_en == '0 |=> conv_start == '0;
	endproperty
	a_off: assert property (p_off) else $error("start while all channels off");
	property p_lock;
		(|phase_en[0]) && $past(|phase_en[0]) |-> $stable(dest_sel[0]) && $stable(xfer_sel[0]);
	endproperty
	a_lock: assert property (p_lock) else $error("setup changed while enabled");
	property p_tsel;
		(|phase_en[1]) && $past(|phase_en[1]) |-> $stable(timer_sel[1]);
	endproperty
	a_tsel: assert property (p_tsel) else $error("timer select changed while enabled");
	property p_mode;
		(|phase_en[0]) && $past(|phase_en[0]) |-> $stable(offset_mode[0]) && $stable(trig_sel[0]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode changed while enabled");
	property p_pulse;
		conv_start[0] && phase_en[1] == '0 |=> !conv_start[0];
	endproperty
	a_pulse: assert property (p_pulse) else $error("start wider than one cycle");
	property p_match;
		$rose(conv_start[0]) && $past(phase_en[1]) == '0 && !$past(offset_mode[0]) && $past(dest_sel[0]) == '0
			|-> $past(tmr_count[timer_sel[0]]) == $past(active_cmp[0]) && $past(phase_en[0]) != '0;
	endproperty
	a_match: assert property (p_match) else $error("start without count match");
	property p_direct;
		cmp_wr[0] && xfer_sel[0] == XFER_NONE |=> active_cmp[0] == $past(wr_data);
	endproperty
	a_direct: assert property (p_direct) else $error("unbuffered compare write lost");
	property p_shadow;
		cmp_wr[0] && xfer_sel[0] != XFER_NONE && tmr_phase[timer_sel[0]] == PH_UP |=> $stable(active_cmp[0]);
	endproperty
	a_shadow: assert property (p_shadow) else $error("buffered write reached active value");
	property p_abort;
		!offset_mode[0] || phase_en[0] == '0 |=> !ofs_busy[0];
	endproperty
	a_abort: assert property (p_abort) else $error("delay count not aborted");
endmodule : asc_link_props
`default_nettype wire

// >>> dv/adc_start_compare_tb.sv
`default_nettype none
module adc_start_compare_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import asc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic pclk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0;
	logic [APB_DW-1:0] prdata, rd;
	logic pready, pslverr, er;
	logic [CNT_W-1:0] tc [NTMR] = '{default: '0};
	asc_phase_e tp [NTMR] = '{default: PH_STOP};
	logic [MCNT_W-1:0] tmk [NTMR] = '{default: '0};
	logic [NOCU-1:0] ocm = '0;
	logic [NCONV-1:0] cs;
	int error_cnt = 0;
	int n_compared = 0;
	int c0 = 0;
	int c1 = 0;
	int b0, b1;
	asc_link_if lnk ();
	asc_channel_ctl i_asc_channel_ctl (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(lnk.ctl));
	asc_converter_start_comparator i_asc_converter_start_comparator (.pclk(pclk), .presetn(presetn),
		.pclk_en(pclk_en), .tmr_count(tc), .tmr_phase(tp), .tmr_mask_cnt(tmk), .oc_match(ocm),
		.conv_start(cs), .lnk(lnk.dev));
	asc_link_props i_asc_link_props (.pclk(pclk), .presetn(presetn), .phase_en(lnk.phase_en),
		.offset_mode(lnk.offset_mode), .trig_sel(lnk.trig_sel), .xfer_sel(lnk.xfer_sel), .dest_sel(lnk.dest_sel),
		.timer_sel(lnk.timer_sel), .cmp_wr(lnk.cmp_wr), .wr_data(lnk.wr_data), .active_cmp(lnk.active_cmp),
		.ofs_busy(lnk.ofs_busy), .tmr_count(tc), .tmr_phase(tp), .conv_start(cs));
	always #5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		c0 <= c0 + int'(cs[0]);
		c1 <= c1 + int'(cs[1]);
	end
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 40);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			error_cnt++;
			finish_test();
		end
	endtask : apb
	task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rchk(input string nm, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] exp);
		apb(1'b0, a, '0);
		chk(nm, rd, exp);
	endtask : rchk
	// Timer 1 runs apart so a wrong timer select shows
	task automatic tm(input logic [CNT_W-1:0] c, input asc_phase_e ph, input logic [MCNT_W-1:0] m, input int n);
		@(posedge pclk);
		tc <= '{c, ~c, c};
		tp <= '{ph, ph, ph};
		tmk <= '{m, 4'h0, m};
		repeat (n) @(posedge pclk);
	endtask : tm
	task automatic mark;
		b0 = c0;
		b1 = c1;
	endtask : mark
	task automatic pulses(input int e0, input int e1);
		repeat (2) @(posedge pclk);
		chk("starts0", 32'(c0 - b0), 32'(e0));
		chk("starts1", 32'(c1 - b1), 32'(e1));
	endtask : pulses
	task automatic sweep;
		for (int i = 14; i < 36; i++)
			tm(16'(i), PH_UP, 4'h0, 2);
	endtask : sweep
	task automatic t_regs;
		rchk("mode", 12'h000, 32'h0);
		rchk("status", 12'h050, 32'h0);
		rchk("unmapped", 12'hFFC, 32'h0);
		chk("slverr", 32'(er), 32'h1);
		$display("test regs done");
	endtask : t_regs
	task automatic t_norm;
		wr(12'h00C, 32'h10);
		wr(12'h004, 32'h0);
		wr(12'h000, 32'h2);
		rchk("cmp", 12'h00C, 32'h10);
		mark();
		tm(16'h000F, PH_UP, 4'h0, 2);
		tm(16'h0010, PH_UP, 4'h0, 4);
		tm(16'h0011, PH_UP, 4'h0, 2);
		pulses(1, 0);
		mark();
		tm(16'h0010, PH_DOWN, 4'h0, 3);
		tm(16'h0010, PH_ZERO, 4'h0, 3);
		pulses(0, 0);
		wr(12'h00C, 32'hFFFF);
		wr(12'h000, 32'hF);
		mark();
		tm(16'h0005, PH_PEAK, 4'h0, 3);
		tm(16'h0005, PH_STOP, 4'h0, 3);
		pulses(0, 0);
		mark();
		tm(16'hFFFF, PH_PEAK, 4'h0, 3);
		pulses(1, 0);
		$display("test normal done");
	endtask : t_norm
	task automatic t_lock;
		rchk("status", 12'h050, 32'h1);
		wr(12'h004, 32'h8);
		rchk("setup", 12'h004, 32'h0);
		wr(12'h000, 32'h2F);
		rchk("mode", 12'h000, 32'hF);
		wr(12'h000, 32'h30);
		rchk("mode", 12'h000, 32'h30);
		wr(12'h008, 32'h2);
		rchk("link", 12'h008, 32'h2);
		wr(12'h008, 32'h0);
		$display("test lock done");
	endtask : t_lock
	task automatic t_mask;
		wr(12'h00C, 32'h0);
		wr(12'h000, 32'h1);
		wr(12'h040, 32'h13);
		rchk("mask", 12'h040, 32'h13);
		mark();
		tm(16'h0000, PH_ZERO, 4'h2, 3);
		tm(16'h0000, PH_ZERO, 4'h3, 3);
		pulses(1, 0);
		$display("test mask done");
	endtask : t_mask
	task automatic t_or;
		wr(12'h040, 32'h0);
		wr(12'h00C, 32'h10);
		wr(12'h000, 32'h2);
		wr(12'h018, 32'h2);
		wr(12'h01C, 32'h20);
		wr(12'h010, 32'h2);
		mark();
		sweep();
		pulses(2, 0);
		wr(12'h010, 32'h0);
		wr(12'h014, 32'h8);
		wr(12'h010, 32'h2);
		mark();
		sweep();
		pulses(1, 1);
		$display("test or done");
	endtask : t_or
	task automatic t_buf;
		wr(12'h000, 32'h0);
		wr(12'h004, 32'h1);
		wr(12'h000, 32'h2);
		tm(16'h0040, PH_UP, 4'h0, 1);
		wr(12'h00C, 32'h30);
		rchk("active", 12'h00C, 32'h10);
		tm(16'h0000, PH_ZERO, 4'h0, 2);
		rchk("active", 12'h00C, 32'h30);
		$display("test buffer done");
	endtask : t_buf
	// Offset mode: delay of three count changes, retrigger, abort
	task automatic t_ofs;
		wr(12'h010, 32'h0);
		wr(12'h000, 32'h10);
		wr(12'h004, 32'h0);
		wr(12'h00C, 32'h3);
		wr(12'h000, 32'h12);
		tm(16'h0050, PH_UP, 4'h0, 2);
		@(posedge pclk);
		ocm <= 2'h2;
		rchk("status", 12'h050, 32'h1);
		@(posedge pclk);
		ocm <= 2'h1;
		rchk("status", 12'h050, 32'h101);
		mark();
		tm(16'h0051, PH_UP, 4'h0, 2);
		tm(16'h0052, PH_UP, 4'h0, 2);
		pulses(0, 0);
		mark();
		tm(16'h0053, PH_UP, 4'h0, 2);
		pulses(1, 0);
		rchk("status", 12'h050, 32'h1);
		@(posedge pclk);
		ocm <= 2'h0;
		@(posedge pclk);
		ocm <= 2'h1;
		rchk("status", 12'h050, 32'h101);
		wr(12'h000, 32'h0);
		rchk("status", 12'h050, 32'h0);
		ocm <= 2'h0;
		$display("test offset done");
	endtask : t_ofs
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_norm();
		t_lock();
		t_mask();
		t_or();
		t_buf();
		t_ofs();
		finish_test();
	end
	initial
	begin
		repeat (50000) @(posedge pclk);
		error_cnt++;
		finish_test();
	end
endmodule : adc_start_compare_tb
`default_nettype wire
